/* hdl/acs_pkg.sv */
// Package of register offsets, field layouts, reset values and timing constants.
package acs_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   // Printed offsets are not multiples of four, so they are indices.
   localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h1F;
   localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h9F;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h1E;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h9E;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hA0;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA1;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hA2;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int POWER_BIT = 0;
   localparam int START_BIT = 1;
   localparam int CHAN_LSB = 2;
   localparam int REF_BIT = 6;
   localparam int JUSTIFY_BIT = 7;
   localparam int CLKSEL_LSB = 4;
   localparam logic [7:0] CLOCK_CONFIG_MASK = 8'h70;
   localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CLOCK_CONFIG_RESET = 8'h00;

   // Interrupt status bits.
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_BADCH_BIT = 1;
   localparam int IRQ_WIDTH = 2;

   // ----------------------------------------------------------------
   // Conversion clock selection
   // ----------------------------------------------------------------
   localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
   localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
   localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
   localparam logic [2:0] CLKSEL_DIV4 = 3'h4;
   localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
   localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
   localparam logic [1:0] CLKSEL_RC_LOW = 2'h3;

   localparam logic [3:0] CHAN_LAST_VALID = 4'hD;
   localparam int RESULT_BITS = 10;
   // Bit periods spent: one sample slot, ten bits, one settle slot.
   localparam int CONV_BIT_PERIODS = 12;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 100000;
   localparam int RC_FREQ_MAX_KHZ = 500;
   // Longest-period style: round up the divide so the rate stays <= max.
   localparam int RC_DIV_CYCLES =
      (CLK_FREQ_KHZ + RC_FREQ_MAX_KHZ - 1) / RC_FREQ_MAX_KHZ;

   typedef enum logic [2:0]
   {
      ACS_IDLE = 3'b001,
      ACS_CONV = 3'b010,
      ACS_DONE = 3'b100
   } acs_state_t;

endpackage : acs_pkg

/* hdl/acs_tick_if.sv */
// Interface carrying conversion-clock ticks from the divider to the sequencer.
`timescale 1ns/1ps
`default_nettype none

interface acs_tick_if;
   logic [2:0] clk_select;
   logic run;
   logic tick;
   logic rc_mode;

   modport divider
   (
      input clk_select,
      input run,
      output tick,
      output rc_mode
   );
   modport sequencer
   (
      output clk_select,
      output run,
      input tick,
      input rc_mode
   );
endinterface : acs_tick_if

`default_nettype wire

/* hdl/acs_clock_divider.sv */
// Conversion clock divider: system clock divides or the internal RC rate.
`timescale 1ns/1ps
`default_nettype none

module acs_clock_divider
(
   input wire logic CLK,
   input wire logic RST,
   acs_tick_if.divider tk
);
   import acs_pkg::*;

   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] limit;
   logic tick_q;
   logic tick_d;

   // ----------------------------------------------------------------
   // Divide ratio decode
   // ----------------------------------------------------------------
   function automatic logic [7:0] div_of(input logic [2:0] sel);
      logic [7:0] r;
      r = 8'h02;
      if (sel[1:0] == CLKSEL_RC_LOW)
         r = 8'(RC_DIV_CYCLES); // R2
      else
         unique case (sel) // R1
            CLKSEL_DIV2: r = 8'h02;
            CLKSEL_DIV4: r = 8'h04;
            CLKSEL_DIV8: r = 8'h08;
            CLKSEL_DIV16: r = 8'h10;
            CLKSEL_DIV32: r = 8'h20;
            CLKSEL_DIV64: r = 8'h40;
            default: r = 8'h02;
         endcase
      return r;
   endfunction : div_of

   always_comb
   begin
      limit = div_of(tk.clk_select);
      cnt_d = 8'h00;
      tick_d = 1'b0;
      if (tk.run)
      begin
         if (cnt_q >= limit - 8'h01)
         begin
            tick_d = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tk.tick = tick_q;
   assign tk.rc_mode = (tk.clk_select[1:0] == CLKSEL_RC_LOW);

   property p_tick_spacing;
      @(posedge CLK) disable iff (RST)
      tick_q |=> !tick_q;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("conversion tick lasted more than one cycle");

endmodule : acs_clock_divider

`default_nettype wire

/* hdl/acs_result_former.sv */
// Places the 10-bit result into the high and low result bytes.
`timescale 1ns/1ps
`default_nettype none

module acs_result_former
(
   input wire logic [9:0] value,
   input wire logic right_justify,
   output logic [15:0] pair
);
   import acs_pkg::*;

   always_comb
   begin
      if (right_justify)
         pair = {6'h00, value}; // R9
      else
         pair = {value, 6'h00}; // R9
   end

endmodule : acs_result_former

`default_nettype wire

/* hdl/acs_sequencer.sv */
// Converter control sequencer: control registers, start/done, results, irq.
// Function
// [R1] Clock field codes divide the system clock by 2,4,8,16,32,64.
// [R2] Codes x11 clock the converter from the internal RC, at most 500 kHz.
// [R3] Clock register bit 7 and bits 3..0 read zero, writes ignored.
// [R4] Main control bit 0 powers the converter; zero shuts it off.
// [R5] Writing one to bit 1 starts; it reads one while converting.
// [R6] Hardware clears the start bit when the conversion completes.
// [R7] Channel field selects inputs 0..11, references 12..13; 14,15 reserved.
// [R8] Main control bit 6 picks external reference pin or supply.
// [R9] Main control bit 7 right-justifies result when one, left when zero.
// [R10] At completion the result appears in high and low result bytes.
// [R11] Software waits about 5 us after a channel change before starting.
// [R12] All writable control bits reset to zero at power-on.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ,
   output logic CONV_POWER,
   output logic CONV_REF_EXT,
   output logic [3:0] CONV_CHANNEL,
   output logic CONV_RC_CLOCK,
   output logic CONV_TICK,
   output logic CONV_SAMPLE,
   input wire logic CONV_BIT_IN
);
   import acs_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] main_q;
   logic [7:0] main_d;
   logic [2:0] clksel_q;
   logic [2:0] clksel_d;
   logic [15:0] result_q;
   logic [15:0] result_d;
   logic [9:0] sar_q;
   logic [9:0] sar_d;
   logic [3:0] bitcnt_q;
   logic [3:0] bitcnt_d;
   acs_state_t state_q;
   acs_state_t state_d;
   logic [IRQ_WIDTH-1:0] irq_stat_q;
   logic [IRQ_WIDTH-1:0] irq_stat_d;
   logic [IRQ_WIDTH-1:0] irq_en_q;
   logic [IRQ_WIDTH-1:0] irq_en_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic bit_meta_q;
   logic bit_sync_q;
   logic [15:0] formed;
   logic done_evt;
   logic badch_evt;
   logic start_wr;

   acs_tick_if tk();

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : hit

   acs_clock_divider u_div
   (
      .CLK(CLK),
      .RST(RST),
      .tk(tk.divider)
   );

   acs_result_former u_form
   (
      .value(sar_q),
      .right_justify(main_q[JUSTIFY_BIT]),
      .pair(formed)
   );

   assign tk.clk_select = clksel_q;
   assign tk.run = (state_q == ACS_CONV);

   // The returned comparator bit comes from the analog side, so it is
   // brought into this domain through two flops.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         bit_meta_q <= 1'b0;
         bit_sync_q <= 1'b0;
      end
      else
      begin
         bit_meta_q <= CONV_BIT_IN;
         bit_sync_q <= bit_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Control, sequencing and results
   // ----------------------------------------------------------------
   assign start_wr = WR && hit(ADDR, ADDR_MAIN_CONTROL)
      && WDATA[START_BIT] && WDATA[POWER_BIT];

   always_comb
   begin
      main_d = main_q;
      clksel_d = clksel_q;
      state_d = state_q;
      sar_d = sar_q;
      bitcnt_d = bitcnt_q;
      result_d = result_q;
      done_evt = 1'b0;
      badch_evt = 1'b0;
      if (WR && hit(ADDR, ADDR_MAIN_CONTROL))
      begin
         // A start write while busy keeps the bit set; zero aborts.
         main_d = WDATA;
      end
      if (WR && hit(ADDR, ADDR_CLOCK_CONFIG))
      begin
         clksel_d = WDATA[CLKSEL_LSB +: 3]; // R3
      end
      unique case (state_q)
         ACS_IDLE:
         begin
            main_d[START_BIT] = main_d[START_BIT] & start_wr;
            if (start_wr) // R5
            begin
               state_d = ACS_CONV;
               sar_d = '0;
               bitcnt_d = 4'h0;
               badch_evt = (WDATA[CHAN_LSB +: 4] > CHAN_LAST_VALID); // R7
            end
         end
         ACS_CONV:
         begin
            if (!main_d[POWER_BIT] || !main_d[START_BIT]) // R4
            begin
               state_d = ACS_IDLE;
               main_d[START_BIT] = 1'b0;
            end
            else if (tk.tick)
            begin
               bitcnt_d = bitcnt_q + 4'h1;
               if (bitcnt_q >= 4'h1 && bitcnt_q <= 4'(RESULT_BITS))
                  sar_d = {sar_q[8:0], bit_sync_q};
               if (bitcnt_q == 4'(CONV_BIT_PERIODS - 1))
                  state_d = ACS_DONE;
            end
         end
         ACS_DONE:
         begin
            result_d = formed; // R10
            main_d[START_BIT] = 1'b0; // R6
            done_evt = 1'b1;
            state_d = ACS_IDLE;
         end
         default:
         begin
            state_d = ACS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         main_q <= MAIN_CONTROL_RESET; // R12
         clksel_q <= CLOCK_CONFIG_RESET[CLKSEL_LSB +: 3]; // R12
         state_q <= ACS_IDLE;
         sar_q <= '0;
         bitcnt_q <= 4'h0;
         result_q <= 16'h0000;
      end
      else
      begin
         main_q <= main_d;
         clksel_q <= clksel_d;
         state_q <= state_d;
         sar_q <= sar_d;
         bitcnt_q <= bitcnt_d;
         result_q <= result_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts and read port
   // ----------------------------------------------------------------
   always_comb
   begin
      irq_en_d = irq_en_q;
      irq_stat_d = irq_stat_q;
      if (WR && hit(ADDR, ADDR_IRQ_ENABLE))
         irq_en_d = WDATA[IRQ_WIDTH-1:0];
      if (WR && hit(ADDR, ADDR_IRQ_CLEAR))
         irq_stat_d = irq_stat_q & ~WDATA[IRQ_WIDTH-1:0];
      // Setting after clearing lets a same-cycle event win.
      if (done_evt)
         irq_stat_d[IRQ_DONE_BIT] = 1'b1;
      if (badch_evt)
         irq_stat_d[IRQ_BADCH_BIT] = 1'b1;
      rdata_d = 8'h00;
      if (RD)
      begin
         unique case (1'b1)
            hit(ADDR, ADDR_MAIN_CONTROL): rdata_d = main_q; // R5
            hit(ADDR, ADDR_CLOCK_CONFIG):
               rdata_d = {1'b0, clksel_q, 4'h0} & CLOCK_CONFIG_MASK; // R3
            hit(ADDR, ADDR_RESULT_HIGH): rdata_d = result_q[15:8]; // R10
            hit(ADDR, ADDR_RESULT_LOW): rdata_d = result_q[7:0]; // R10
            hit(ADDR, ADDR_IRQ_STATUS): rdata_d = 8'(irq_stat_q);
            hit(ADDR, ADDR_IRQ_ENABLE): rdata_d = 8'(irq_en_q);
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         irq_en_q <= '0;
         irq_stat_q <= '0;
         rdata_q <= 8'h00;
      end
      else
      begin
         irq_en_q <= irq_en_d;
         irq_stat_q <= irq_stat_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;
   assign IRQ = |(irq_stat_q & irq_en_q);
   assign CONV_POWER = main_q[POWER_BIT]; // R4
   assign CONV_REF_EXT = main_q[REF_BIT]; // R8
   assign CONV_CHANNEL = main_q[CHAN_LSB +: 4]; // R7
   assign CONV_RC_CLOCK = tk.rc_mode; // R2
   assign CONV_TICK = tk.tick;
   assign CONV_SAMPLE = (state_q == ACS_CONV) && (bitcnt_q == 4'h0);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_start_enters_conv;
      @(posedge CLK) disable iff (RST)
      (state_q == ACS_IDLE && start_wr) |=>
         (state_q == ACS_CONV && main_q[START_BIT]);
   endproperty
   a_start_enters_conv: assert property (p_start_enters_conv) // R5
      else $error("start write did not begin a conversion");

   property p_busy_flag;
      @(posedge CLK) disable iff (RST)
      (state_q == ACS_CONV) |-> main_q[START_BIT];
   endproperty
   a_busy_flag: assert property (p_busy_flag) // R5
      else $error("start bit low while converting");

   property p_done_clears;
      @(posedge CLK) disable iff (RST)
      (state_q == ACS_DONE) |=>
         (!main_q[START_BIT] && irq_stat_q[IRQ_DONE_BIT]);
   endproperty
   a_done_clears: assert property (p_done_clears) // R6
      else $error("start bit not cleared at completion");

   property p_result_form;
      @(posedge CLK) disable iff (RST)
      (state_q == ACS_DONE) |=> ($past(main_q[JUSTIFY_BIT]) ?
         result_q[15:10] == 6'h00 : result_q[5:0] == 6'h00);
   endproperty
   a_result_form: assert property (p_result_form) // R9
      else $error("result justification wrong");

   property p_result_latch;
      @(posedge CLK) disable iff (RST)
      (state_q == ACS_DONE) |=> (result_q == $past(formed));
   endproperty
   a_result_latch: assert property (p_result_latch) // R10
      else $error("result not latched on completion");

   property p_clk_read;
      @(posedge CLK) disable iff (RST)
      (RD && hit(ADDR, ADDR_CLOCK_CONFIG)) |=> (RDATA[7] == 1'b0
         && RDATA[3:0] == 4'h0 && RDATA[6:4] == $past(clksel_q));
   endproperty
   a_clk_read: assert property (p_clk_read) // R3
      else $error("clock register read returned bad bits");

   property p_power_off_stops;
      @(posedge CLK) disable iff (RST)
      (state_q == ACS_CONV && WR && hit(ADDR, ADDR_MAIN_CONTROL)
         && !WDATA[POWER_BIT]) |=> (state_q == ACS_IDLE);
   endproperty
   a_power_off_stops: assert property (p_power_off_stops) // R4
      else $error("power off did not stop conversion");

   property p_ref_follows;
      @(posedge CLK) disable iff (RST)
      (WR && hit(ADDR, ADDR_MAIN_CONTROL)) |=>
         (CONV_REF_EXT == $past(WDATA[REF_BIT])
         && CONV_CHANNEL == $past(WDATA[CHAN_LSB +: 4]));
   endproperty
   a_ref_follows: assert property (p_ref_follows) // R8
      else $error("reference or channel output wrong");

   // A clear that meets no new event must leave the written bits low.
   property p_irq_clear;
      @(posedge CLK) disable iff (RST)
      (WR && hit(ADDR, ADDR_IRQ_CLEAR) && !done_evt && !badch_evt) |=>
         ((irq_stat_q & $past(WDATA[IRQ_WIDTH-1:0])) == '0);
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt status bit not cleared");

   c_conv_done: cover property (@(posedge CLK) disable iff (RST)
      state_q == ACS_DONE);
   c_right: cover property (@(posedge CLK) disable iff (RST)
      state_q == ACS_DONE && main_q[JUSTIFY_BIT]);
   c_rc: cover property (@(posedge CLK) disable iff (RST)
      CONV_RC_CLOCK && state_q == ACS_CONV);
   c_abort: cover property (@(posedge CLK) disable iff (RST)
      state_q == ACS_CONV && WR && !WDATA[POWER_BIT]);

endmodule : acs_sequencer

`default_nettype wire

/* verif/tb_adc_control_sequencer.sv */
// Self-checking testbench for the converter control sequencer.
`timescale 1ns/1ps
`default_nettype none

module tb_adc_control_sequencer;
   import acs_pkg::*;

   // ----------------------------------------------------------------
   // Signals and design instance
   // ----------------------------------------------------------------
   localparam logic [9:0] PATTERN = 10'h2B5;
   logic clk, rst, wr, rd, bit_in, irq, power, ref_ext, rc, tick, sample;
   logic [7:0] addr, wdata, rdata, d;
   logic [3:0] channel;
   int err_count, num_checks, n;
   logic [2:0] codes [8] = '{3'h7, 3'h3, 3'h6, 3'h2, 3'h5, 3'h1, 3'h4, 3'h0};
   int divs [8] = '{RC_DIV_CYCLES, RC_DIV_CYCLES, 64, 32, 16, 8, 4, 2};

   acs_sequencer u_dut
   (
      .CLK(clk),
      .RST(rst),
      .ADDR(addr),
      .WDATA(wdata),
      .WR(wr),
      .RD(rd),
      .RDATA(rdata),
      .IRQ(irq),
      .CONV_POWER(power),
      .CONV_REF_EXT(ref_ext),
      .CONV_CHANNEL(channel),
      .CONV_RC_CLOCK(rc),
      .CONV_TICK(tick),
      .CONV_SAMPLE(sample),
      .CONV_BIT_IN(bit_in)
   );

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      if (err_count == 0 && num_checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
         err_count++;
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg

   task automatic next_tick(output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1;
         k++;
      end
      while (tick !== 1'b1 && k < 400);
      if (k >= 400)
      begin
         $display("unexpected conversion tick: expected 1, seen 0");
         err_count++;
         summarize();
      end
   endtask : next_tick

   task automatic wait_done();
      int i;
      i = 0;
      d = 8'h02;
      while (d[START_BIT] !== 1'b0 && i < 500)
      begin
         rd_reg(ADDR_MAIN_CONTROL, d);
         i++;
      end
      if (i >= 500)
      begin
         $display("unexpected start bit: expected 0, seen %h", d);
         err_count++;
         summarize();
      end
   endtask : wait_done

   // The comparator bit for each tick is set one tick ahead, so the
   // two-flop synchroniser has long settled before it is shifted in.
   task automatic conv(input logic just);
      int k;
      bit_in <= 1'b0;
      wr_reg(ADDR_MAIN_CONTROL, {just, 7'h01});
      repeat (500) @(posedge clk);
      wr_reg(ADDR_MAIN_CONTROL, {just, 7'h03});
      for (k = 1; k <= 11; k++)
      begin
         next_tick(n);
         bit_in <= (k <= 10) ? PATTERN[10 - k] : ~PATTERN[0];
      end
      wait_done();
      rd_reg(ADDR_RESULT_HIGH, d);
      check("result high", just ? {6'h00, PATTERN[9:8]} : PATTERN[9:2], d);
      rd_reg(ADDR_RESULT_LOW, d);
      check("result low", just ? PATTERN[7:0] : {PATTERN[1:0], 6'h00}, d);
   endtask : conv

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      $display("unexpected run length: expected end, seen hang");
      err_count++;
      summarize();
   end

   initial
   begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      bit_in = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("power", 8'h00, {7'h00, power});
      check("irq", 8'h00, {7'h00, irq});
      rd_reg(ADDR_MAIN_CONTROL, d);
      check("main control", MAIN_CONTROL_RESET, d);
      rd_reg(ADDR_CLOCK_CONFIG, d);
      check("clock config", CLOCK_CONFIG_RESET, d);
      rd_reg(ADDR_IRQ_ENABLE, d);
      check("irq enable", 8'h00, d);
      rd_reg(8'h55, d);
      check("unmapped", 8'h00, d);
      wr_reg(ADDR_IRQ_STATUS, 8'hFF);
      rd_reg(ADDR_IRQ_STATUS, d);
      check("irq status", 8'h00, d);
      wr_reg(ADDR_CLOCK_CONFIG, 8'hFF);
      rd_reg(ADDR_CLOCK_CONFIG, d);
      check("clock config", CLOCK_CONFIG_MASK, d);
      wr_reg(ADDR_MAIN_CONTROL, 8'h45);
      check("ref ext", 8'h01, {7'h00, ref_ext});
      check("power", 8'h01, {7'h00, power});
      rd_reg(ADDR_MAIN_CONTROL, d);
      check("main control", 8'h45, d);
      for (int c = 0; c < 14; c++)
      begin
         wr_reg(ADDR_MAIN_CONTROL, {2'h0, 4'(c), 2'h1});
         check("channel", 8'(c), {4'h0, channel});
      end
      // A start without power in the same write must be ignored.
      wr_reg(ADDR_MAIN_CONTROL, 8'h02);
      check("power", 8'h00, {7'h00, power});
      rd_reg(ADDR_MAIN_CONTROL, d);
      check("main control", 8'h00, d);
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(ADDR_CLOCK_CONFIG, {1'b0, codes[i], 4'h0});
         check("rc clock", {7'h00, codes[i][1:0] == 2'h3}, {7'h00, rc});
         wr_reg(ADDR_MAIN_CONTROL, 8'h03);
         check("sample", 8'h01, {7'h00, sample});
         rd_reg(ADDR_MAIN_CONTROL, d);
         check("main control", 8'h03, d);
         next_tick(n);
         next_tick(n);
         check("tick spacing", 8'(divs[i]), 8'(n));
         wr_reg(ADDR_MAIN_CONTROL, 8'h01);
         rd_reg(ADDR_MAIN_CONTROL, d);
         check("main control", 8'h01, d);
         rd_reg(ADDR_IRQ_STATUS, d);
         check("irq status", 8'h00, d);
      end
      wr_reg(ADDR_IRQ_CLEAR, 8'h03);
      wr_reg(ADDR_MAIN_CONTROL, 8'h3B);
      rd_reg(ADDR_IRQ_STATUS, d);
      check("irq status", 8'h02, d);
      wr_reg(ADDR_MAIN_CONTROL, 8'h01);
      wr_reg(ADDR_IRQ_CLEAR, 8'h03);
      wr_reg(ADDR_IRQ_ENABLE, 8'h00);
      wr_reg(ADDR_CLOCK_CONFIG, 8'h10);
      conv(1'b1);
      rd_reg(ADDR_IRQ_STATUS, d);
      check("irq status", 8'h01, d);
      check("irq", 8'h00, {7'h00, irq});
      wr_reg(ADDR_IRQ_ENABLE, 8'h03);
      check("irq", 8'h01, {7'h00, irq});
      rd_reg(ADDR_IRQ_CLEAR, d);
      check("irq clear", 8'h00, d);
      wr_reg(ADDR_IRQ_CLEAR, 8'h01);
      check("irq", 8'h00, {7'h00, irq});
      rd_reg(ADDR_IRQ_STATUS, d);
      check("irq status", 8'h00, d);
      conv(1'b0);
      check("irq", 8'h01, {7'h00, irq});
      summarize();
   end
endmodule : tb_adc_control_sequencer

`default_nettype wire
